// ### tspi_map.svh
`ifndef TSPI_MAP_SVH
`define TSPI_MAP_SVH
`define TSPI_NUM_PFI 10
`define TSPI_NUM_GIO 8
`define TSPI_NUM_PAIR 8
`define TSPI_ADDR_W 4
`define TSPI_DATA_W 32
`define TSPI_REG_PFI_OE 4'h0
`define TSPI_REG_GIO_DIR 4'h1
`define TSPI_REG_GIO_OUT 4'h2
`define TSPI_REG_GIO_IN 4'h3
`define TSPI_REG_STROBE 4'h4
`define TSPI_REG_PAIR_CFG 4'h5
`define TSPI_REG_PFI_IN 4'h6
`define TSPI_REG_MODE 4'h7
`define TSPI_REG_ROUTE0 4'h8
`define TSPI_REG_ROUTE1 4'h9
`define TSPI_REG_ROUTE2 4'ha
`define TSPI_REG_ROUTE3 4'hb
`define TSPI_MODE_PRETRIG 0
`define TSPI_MODE_PER_CONVERSION_CLOCK_OUT_EN 1
`define TSPI_MODE_SCANNING 2
`define TSPI_GIO_DIR_CTR0 6
`define TSPI_GIO_DIR_CTR1 7
`define TSPI_PFI_OE_RST 10'h000
`define TSPI_GIO_DIR_RST 8'h00
`define TSPI_PAIR_CFG_RST 8'h00
`define TSPI_STROBE_RST 1'b1
`define TSPI_SEL_W 5
`define TSPI_NUM_ROUTES 4
`define TSPI_PULSE_NS 8
`define TSPI_CLK_NS 4
`define TSPI_PULSE_CYC ((`TSPI_PULSE_NS + `TSPI_CLK_NS - 1) / `TSPI_CLK_NS)
`endif

// ### tspi_pkg.sv
package tspi_pkg;
    typedef enum logic [1:0] {
        tspi_acq_idle,
        tspi_acq_pre,
        tspi_acq_post
    } tspi_acq_e;
    typedef logic [4:0] tspi_sel_t;
endpackage : tspi_pkg

// ### tspi_sync.sv
`include "tspi_map.svh"
module tspi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : tspi_sync

// ### tspi_pulse.sv
`include "tspi_map.svh"
module tspi_pulse (
    input wire logic clk,
    input wire logic rstn,
    input wire logic trig,
    output logic pulse
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;

    // Stretching keeps each pulse wide enough to be seen off the board.
    assign nxt_cnt = trig ? 3'(`TSPI_PULSE_CYC) :
                     (cnt_ff != 3'h0) ? cnt_ff - 3'h1 : 3'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign pulse = (cnt_ff != 3'h0);
endmodule : tspi_pulse

// ### tspi_timing_pins.sv
`include "tspi_map.svh"
module tspi_timing_pins
    import tspi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [`TSPI_ADDR_W-1:0] reg_addr,
    input wire logic [`TSPI_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`TSPI_DATA_W-1:0] reg_rdata,
    input wire logic acq_start_evt,
    input wire logic posttrig_start_evt,
    input wire logic conversion_evt,
    input wire logic update_evt,
    input wire logic waveform_start_evt,
    input wire logic scan_start_evt,
    input wire logic ctr0_out,
    input wire logic ctr1_out,
    input wire logic freq_gen_out,
    input wire logic [`TSPI_NUM_PFI-1:0] pfi_in,
    output logic [`TSPI_NUM_PFI-1:0] pfi_out,
    output logic [`TSPI_NUM_PFI-1:0] pfi_oe,
    input wire logic [`TSPI_NUM_GIO-1:0] gio_in,
    output logic [`TSPI_NUM_GIO-1:0] gio_out,
    output logic [`TSPI_NUM_GIO-1:0] gio_oe,
    output logic per_conversion_clock_out,
    output logic software_strobe_n,
    output logic counter_zero_result_out,
    output logic counter_one_result_out,
    output logic divided_clock_out,
    output logic [`TSPI_NUM_ROUTES-1:0] route_out,
    output logic counter_zero_up,
    output logic counter_one_up,
    output logic [`TSPI_NUM_PAIR-1:0] pair_differential,
    output logic [1:0] acq_phase
);
    logic [`TSPI_NUM_PFI-1:0] pfi_oe_ff;
    logic [`TSPI_NUM_GIO-1:0] gio_dir_ff;
    logic [`TSPI_NUM_GIO-1:0] gio_out_ff;
    logic [`TSPI_NUM_PAIR-1:0] pair_cfg_ff;
    logic [2:0] mode_ff;
    logic strobe_ff;
    tspi_sel_t route_sel_ff [`TSPI_NUM_ROUTES];
    logic [`TSPI_DATA_W-1:0] rdata_ff;
    logic [`TSPI_DATA_W-1:0] nxt_rdata;
    logic [`TSPI_NUM_PFI-1:0] pfi_s;
    logic [`TSPI_NUM_GIO-1:0] gio_s;
    logic [`TSPI_NUM_PFI-1:0] pfi_drv;
    logic [`TSPI_NUM_PFI-1:0] pfi_out_ff;
    logic [`TSPI_NUM_ROUTES-1:0] route_ff;
    logic [`TSPI_NUM_ROUTES-1:0] route_src;
    logic conv_pulse;
    logic upd_pulse;
    logic scan_pulse;
    logic per_conversion_clock_out_ff;
    logic acq_mark_ff;
    logic post_mark_ff;
    logic wave_mark_ff;
    logic res0_ff;
    logic res1_ff;
    logic freq_ff;
    logic dir0_ff;
    logic dir1_ff;
    tspi_acq_e acq_ff;
    tspi_acq_e nxt_acq;

    tspi_sync #(.W(`TSPI_NUM_PFI)) u_pfi_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(pfi_in),
        .sync_out(pfi_s)
    );

    tspi_sync #(.W(`TSPI_NUM_GIO)) u_gio_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(gio_in),
        .sync_out(gio_s)
    );

    tspi_pulse u_conv_pulse (
        .clk(clk),
        .rstn(rstn),
        .trig(conversion_evt),
        .pulse(conv_pulse)
    );

    tspi_pulse u_upd_pulse (
        .clk(clk),
        .rstn(rstn),
        .trig(update_evt),
        .pulse(upd_pulse)
    );

    tspi_pulse u_scan_pulse (
        .clk(clk),
        .rstn(rstn),
        .trig(scan_start_evt),
        .pulse(scan_pulse)
    );

    wire wr_pfi_oe = reg_wr && (reg_addr == `TSPI_REG_PFI_OE);
    wire wr_gio_dir = reg_wr && (reg_addr == `TSPI_REG_GIO_DIR);
    wire wr_gio_out = reg_wr && (reg_addr == `TSPI_REG_GIO_OUT);
    wire wr_strobe = reg_wr && (reg_addr == `TSPI_REG_STROBE);
    wire wr_pair = reg_wr && (reg_addr == `TSPI_REG_PAIR_CFG);
    wire wr_mode = reg_wr && (reg_addr == `TSPI_REG_MODE);
    wire pretrig = mode_ff[`TSPI_MODE_PRETRIG];
    wire per_conversion_clock_out_on = mode_ff[`TSPI_MODE_PER_CONVERSION_CLOCK_OUT_EN] &&
                      mode_ff[`TSPI_MODE_SCANNING];

    // Posttrigger-only runs enter the post phase for one cycle, but the marker needs pretrig, so it idles.
    always_comb begin
        nxt_acq = acq_ff;
        case (acq_ff)
            tspi_acq_idle: begin
                if (acq_start_evt) begin
                    nxt_acq = pretrig ? tspi_acq_pre : tspi_acq_post;
                end
            end
            tspi_acq_pre: begin
                if (posttrig_start_evt) begin
                    nxt_acq = tspi_acq_idle;
                end
            end
            default: begin
                nxt_acq = tspi_acq_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acq_ff <= tspi_acq_idle;
        end else begin
            acq_ff <= nxt_acq;
        end
    end

    // markers: two registered stages from the event to the pin.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acq_mark_ff <= 1'b0;
            post_mark_ff <= 1'b0;
            wave_mark_ff <= 1'b0;
            per_conversion_clock_out_ff <= 1'b0;
        end else begin
            acq_mark_ff <= acq_start_evt;
            post_mark_ff <= posttrig_start_evt && pretrig &&
                            (acq_ff == tspi_acq_pre);
            wave_mark_ff <= waveform_start_evt;
            per_conversion_clock_out_ff <= per_conversion_clock_out_on && conv_pulse;
        end
    end

    // Dedicated output per pin, in connector order 0 to 9.
    assign pfi_drv[0] = acq_mark_ff;
    assign pfi_drv[1] = post_mark_ff;
    assign pfi_drv[2] = ~conv_pulse;
    assign pfi_drv[3] = route_ff[2];
    assign pfi_drv[4] = route_ff[3];
    assign pfi_drv[5] = ~upd_pulse;
    assign pfi_drv[6] = wave_mark_ff;
    assign pfi_drv[7] = scan_pulse;
    assign pfi_drv[8] = route_ff[0];
    assign pfi_drv[9] = route_ff[1];

    // Any route may pick any pin; sharing a pin between routes is legal.
    genvar g;
    generate
        for (g = 0; g < `TSPI_NUM_ROUTES; g = g + 1) begin : g_route
            wire [4:0] s = route_sel_ff[g];
            assign route_src[g] = (s < 5'(`TSPI_NUM_PFI)) ?
                                  pfi_s[s[3:0]] : 1'b0;
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            route_ff <= '0;
            pfi_out_ff <= '0;
            res0_ff <= 1'b0;
            res1_ff <= 1'b0;
            freq_ff <= 1'b0;
            dir0_ff <= 1'b0;
            dir1_ff <= 1'b0;
        end else begin
            route_ff <= route_src;
            pfi_out_ff <= pfi_drv;
            res0_ff <= ctr0_out;
            res1_ff <= ctr1_out;
            freq_ff <= freq_gen_out;
            // Driven lines read back their own value as direction.
            dir0_ff <= gio_dir_ff[`TSPI_GIO_DIR_CTR0] ?
                       gio_out_ff[`TSPI_GIO_DIR_CTR0] :
                       gio_s[`TSPI_GIO_DIR_CTR0];
            dir1_ff <= gio_dir_ff[`TSPI_GIO_DIR_CTR1] ?
                       gio_out_ff[`TSPI_GIO_DIR_CTR1] :
                       gio_s[`TSPI_GIO_DIR_CTR1];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pfi_oe_ff <= `TSPI_PFI_OE_RST;
            gio_dir_ff <= `TSPI_GIO_DIR_RST;
            gio_out_ff <= '0;
            pair_cfg_ff <= `TSPI_PAIR_CFG_RST;
            mode_ff <= 3'h0;
            strobe_ff <= `TSPI_STROBE_RST;
        end else begin
            if (wr_pfi_oe) begin
                pfi_oe_ff <= reg_wdata[`TSPI_NUM_PFI-1:0];
            end
            if (wr_gio_dir) begin
                gio_dir_ff <= reg_wdata[`TSPI_NUM_GIO-1:0];
            end
            if (wr_gio_out) begin
                gio_out_ff <= reg_wdata[`TSPI_NUM_GIO-1:0];
            end
            if (wr_pair) begin
                pair_cfg_ff <= reg_wdata[`TSPI_NUM_PAIR-1:0];
            end
            if (wr_mode) begin
                mode_ff <= reg_wdata[2:0];
            end
            if (wr_strobe) begin
                strobe_ff <= reg_wdata[0];
            end
        end
    end

    generate
        for (g = 0; g < `TSPI_NUM_ROUTES; g = g + 1) begin : g_sel
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    route_sel_ff[g] <= 5'h1f;
                end else if (reg_wr &&
                             reg_addr == `TSPI_REG_ROUTE0 + 4'(g)) begin
                    route_sel_ff[g] <= reg_wdata[`TSPI_SEL_W-1:0];
                end
            end
        end
    endgenerate

    // Unmapped addresses read zero.
    always_comb begin
        nxt_rdata = '0;
        if (reg_addr == `TSPI_REG_PFI_OE) begin
            nxt_rdata[`TSPI_NUM_PFI-1:0] = pfi_oe_ff;
        end else if (reg_addr == `TSPI_REG_GIO_DIR) begin
            nxt_rdata[`TSPI_NUM_GIO-1:0] = gio_dir_ff;
        end else if (reg_addr == `TSPI_REG_GIO_OUT) begin
            nxt_rdata[`TSPI_NUM_GIO-1:0] = gio_out_ff;
        end else if (reg_addr == `TSPI_REG_GIO_IN) begin
            nxt_rdata[`TSPI_NUM_GIO-1:0] = gio_s;
        end else if (reg_addr == `TSPI_REG_STROBE) begin
            nxt_rdata[0] = strobe_ff;
        end else if (reg_addr == `TSPI_REG_PAIR_CFG) begin
            nxt_rdata[`TSPI_NUM_PAIR-1:0] = pair_cfg_ff;
        end else if (reg_addr == `TSPI_REG_PFI_IN) begin
            nxt_rdata[`TSPI_NUM_PFI-1:0] = pfi_s;
        end else if (reg_addr == `TSPI_REG_MODE) begin
            nxt_rdata[2:0] = mode_ff;
            nxt_rdata[5:4] = acq_ff;
        end else if (reg_addr >= `TSPI_REG_ROUTE0 &&
                     reg_addr <= `TSPI_REG_ROUTE3) begin
            nxt_rdata[`TSPI_SEL_W-1:0] = route_sel_ff[reg_addr[1:0]];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= reg_rd ? nxt_rdata : '0;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pfi_out = pfi_out_ff;
    assign pfi_oe = pfi_oe_ff;
    assign gio_out = gio_out_ff;
    assign gio_oe = gio_dir_ff;
    assign per_conversion_clock_out = per_conversion_clock_out_ff;
    assign software_strobe_n = strobe_ff;
    assign counter_zero_result_out = res0_ff;
    assign counter_one_result_out = res1_ff;
    assign divided_clock_out = freq_ff;
    assign route_out = route_ff;
    assign counter_zero_up = dir0_ff;
    assign counter_one_up = dir1_ff;
    assign pair_differential = pair_cfg_ff;
    assign acq_phase = acq_ff;
endmodule : tspi_timing_pins

// ### tspi_checker.sv
`include "tspi_map.svh"
module tspi_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic acq_start_evt,
    input wire logic posttrig_start_evt,
    input wire logic conversion_evt,
    input wire logic update_evt,
    input wire logic waveform_start_evt,
    input wire logic scan_start_evt,
    input wire logic ctr0_out,
    input wire logic ctr1_out,
    input wire logic freq_gen_out,
    input wire logic [9:0] pfi_out,
    input wire logic [9:0] pfi_oe,
    input wire logic [7:0] gio_oe,
    input wire logic software_strobe_n,
    input wire logic counter_zero_result_out,
    input wire logic counter_one_result_out,
    input wire logic divided_clock_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // A lone scan start must give exactly one stretched pulse.
    sequence scan_alone;
        scan_start_evt ##1 !scan_start_evt [*2];
    endsequence
    sequence scan_pin;
        pfi_out[7] [*2] ##1 !pfi_out[7];
    endsequence
    AST_ACQ_MARK: assert property (acq_start_evt |-> ##2 pfi_out[0])
        else $error("acquisition marker missing");
    AST_POST_CAUSE: assert property ($rose(pfi_out[1]) |->
        $past(posttrig_start_evt, 2)) else $error("stray posttrigger marker");
    AST_CONV_LOW: assert property (conversion_evt |->
        ##2 !pfi_out[2] [*2]) else $error("conversion strobe not low");
    AST_UPD_LOW: assert property (update_evt |->
        ##2 !pfi_out[5] [*2]) else $error("update strobe not low");
    AST_WAVE_MARK: assert property (waveform_start_evt |->
        ##2 pfi_out[6]) else $error("waveform marker missing");
    AST_SCAN_ONCE: assert property (scan_alone |-> scan_pin)
        else $error("scan pulse wrong");
    AST_RESULTS: assert property ($past(rstn) |->
        {counter_zero_result_out, counter_one_result_out, divided_clock_out}
        == $past({ctr0_out, ctr1_out, freq_gen_out}))
        else $error("result pins wrong");
    AST_SW_STROBE: assert property ($changed(software_strobe_n) |->
        $past(reg_wr && reg_addr == `TSPI_REG_STROBE))
        else $error("strobe moved without a write");
    AST_PIN_OE: assert property ($changed(pfi_oe) |->
        $past(reg_wr && reg_addr == `TSPI_REG_PFI_OE))
        else $error("pin enables moved without a write");
    AST_OE_RESET: assert property ($rose(rstn) |->
        pfi_oe == 10'h000 && gio_oe == 8'h00) else $error("drivers on");
endmodule : tspi_checker
bind tspi_timing_pins tspi_checker tspi_checker_i (.clk, .rstn, .reg_addr,
    .reg_wr, .acq_start_evt, .posttrig_start_evt, .conversion_evt,
    .update_evt, .waveform_start_evt, .scan_start_evt, .ctr0_out, .ctr1_out,
    .freq_gen_out, .pfi_out, .pfi_oe, .gio_oe, .software_strobe_n,
    .counter_zero_result_out, .counter_one_result_out, .divided_clock_out);

// ### tspi_far_model.sv
module tspi_far_model (
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe,
    input wire logic [9:0] ext_en,
    input wire logic [9:0] ext_val,
    output logic [9:0] pin_in,
    input wire logic [7:0] line_out,
    input wire logic [7:0] line_oe,
    input wire logic [7:0] lext_en,
    input wire logic [7:0] lext_val,
    output logic [7:0] line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven lines float to their pull-ups; the device driver wins a clash.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en);
    assign line_in = (line_oe & line_out) | (~line_oe & lext_en & lext_val)
        | (~line_oe & ~lext_en);
endmodule : tspi_far_model

// ### testbench.sv
`include "tspi_map.svh"
module testbench import tspi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, reg_wr, reg_rd, ctr0_out, ctr1_out, freq_gen_out;
    logic [3:0] reg_addr, route_out;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0] ev;
    logic [9:0] pfi_in, pfi_out, pfi_oe, ext_en, ext_val;
    logic [7:0] gio_in, gio_out, gio_oe, lext_en, lext_val, pair_differential;
    logic per_conversion_clock_out, software_strobe_n, counter_zero_up;
    logic counter_zero_result_out, counter_one_result_out, divided_clock_out;
    logic counter_one_up;
    logic [1:0] acq_phase;
    logic [2:0] res;
    int fail_count, comparisons;
    assign res = {counter_zero_result_out, counter_one_result_out,
        divided_clock_out};
    tspi_timing_pins tspi_timing_pins_i (.clk, .rstn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .acq_start_evt(ev[0]),
        .posttrig_start_evt(ev[1]), .conversion_evt(ev[2]),
        .update_evt(ev[3]), .waveform_start_evt(ev[4]),
        .scan_start_evt(ev[5]), .ctr0_out, .ctr1_out, .freq_gen_out,
        .pfi_in, .pfi_out, .pfi_oe, .gio_in, .gio_out, .gio_oe,
        .per_conversion_clock_out, .software_strobe_n,
        .counter_zero_result_out, .counter_one_result_out,
        .divided_clock_out, .route_out, .counter_zero_up, .counter_one_up,
        .pair_differential, .acq_phase);
    tspi_far_model tspi_far_model_i (.pin_out(pfi_out), .pin_oe(pfi_oe),
        .ext_en, .ext_val, .pin_in(pfi_in), .line_out(gio_out),
        .line_oe(gio_oe), .lext_en, .lext_val, .line_in(gio_in));
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("read data", reg_rdata, e);
    endtask : rd
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask : settle
    task automatic fire(input int i, input int pin, input logic act,
            input int w, input int nclk);
        int hi;
        hi = 0;
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        for (int k = 1; k <= 6; k++) begin
            @(posedge clk);
            #1;
            hi += per_conversion_clock_out;
            if (k < 1 + w)
                check("active level", pfi_out[pin], act);
            if (k == 1 + w)
                check("idle level", pfi_out[pin], !act);
        end
        check("conversion clock count", hi, nclk);
    endtask : fire
    task automatic t_reset;
        #1;
        check("pin enables", pfi_oe, `TSPI_PFI_OE_RST);
        check("line enables", gio_oe, `TSPI_GIO_DIR_RST);
        check("strobe", software_strobe_n, `TSPI_STROBE_RST);
        check("routes", route_out, 4'h0);
        rd(`TSPI_REG_PFI_OE, 32'h0);
        rd(4'hc, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_events;
        wr(`TSPI_REG_PFI_OE, 32'h3ff);
        wr(`TSPI_REG_MODE, 32'h7);
        fire(0, 0, 1'b1, 1, 0);
        check("phase", acq_phase, tspi_acq_pre);
        fire(1, 1, 1'b1, 1, 0);
        fire(2, 2, 1'b0, 2, 2);
        fire(3, 5, 1'b0, 2, 0);
        fire(4, 6, 1'b1, 1, 0);
        fire(5, 7, 1'b1, 2, 0);
        wr(`TSPI_REG_MODE, 32'h0);
        fire(0, 0, 1'b1, 1, 0);
        fire(1, 1, 1'b1, 0, 0);
        fire(2, 2, 1'b0, 2, 0);
        $display("event test done");
    endtask : t_events
    task automatic t_regs;
        wr(`TSPI_REG_STROBE, 32'h0);
        check("strobe low", software_strobe_n, 1'b0);
        wr(`TSPI_REG_PAIR_CFG, 32'ha5);
        check("strobe held", software_strobe_n, 1'b0);
        check("pairs", pair_differential, 8'ha5);
        rd(`TSPI_REG_PAIR_CFG, 32'ha5);
        wr(`TSPI_REG_STROBE, 32'h1);
        check("strobe high", software_strobe_n, 1'b1);
        $display("register test done");
    endtask : t_regs
    task automatic t_routes;
        @(posedge clk);
        ext_en <= 10'h003;
        ext_val <= 10'h001;
        wr(`TSPI_REG_PFI_OE, 32'h318);
        wr(`TSPI_REG_ROUTE0, 32'h0);
        wr(`TSPI_REG_ROUTE1, 32'h1);
        wr(`TSPI_REG_ROUTE2, 32'h0);
        wr(`TSPI_REG_ROUTE3, 32'h1);
        settle();
        check("routes", route_out, 4'h5);
        check("mirrors", pfi_out & 10'h318, 10'h108);
        @(posedge clk);
        ext_val <= 10'h002;
        settle();
        check("routes", route_out, 4'ha);
        check("mirrors", pfi_out & 10'h318, 10'h210);
        wr(`TSPI_REG_ROUTE3, 32'ha);
        settle();
        check("no pin route", route_out, 4'h2);
        $display("route test done");
    endtask : t_routes
    task automatic t_lines;
        @(posedge clk);
        lext_en <= 8'h80;
        wr(`TSPI_REG_GIO_DIR, 32'h40);
        wr(`TSPI_REG_GIO_OUT, 32'hc0);
        check("line enables", gio_oe, 8'h40);
        check("line six", gio_out[6], 1'b1);
        settle();
        check("dir zero", counter_zero_up, 1'b1);
        check("dir one", counter_one_up, 1'b0);
        rd(`TSPI_REG_GIO_IN, 32'h7f);
        @(posedge clk);
        lext_val <= 8'h80;
        settle();
        check("dir one", counter_one_up, 1'b1);
        check("line seven", gio_oe[7], 1'b0);
        rd(`TSPI_REG_GIO_IN, 32'hff);
        $display("line test done");
    endtask : t_lines
    task automatic t_results;
        @(posedge clk);
        ctr0_out <= 1'b1;
        freq_gen_out <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("results", res, 3'b101);
        @(posedge clk);
        ctr0_out <= 1'b0;
        ctr1_out <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("results", res, 3'b011);
        $display("result test done");
    endtask : t_results
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        fail_count = 0;
        comparisons = 0;
        {rstn, reg_wr, reg_rd, ctr0_out, ctr1_out, freq_gen_out} = 6'h00;
        {reg_addr, reg_wdata, ev} = 42'h0;
        {ext_en, ext_val, lext_en, lext_val} = 36'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_events();
        t_regs();
        t_routes();
        t_lines();
        t_results();
        wrap_up();
    end
endmodule : testbench
